// ==== core/lbb_pkg.sv ====
/*
 * lbb_pkg: shared constants, register map and carrier structs for the
 * lighting driver control core.
 * Assumes a single 125 MHz system clock and a plain strobe register port.
 */
package lbb_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NCH = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_BOOST_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_BUCK1_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] REG_BUCK2_CFG = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h18;

    // control register fields
    localparam int CTRL_BOOST_EN_BIT = 0;
    localparam int CTRL_DIMMING_SOURCE_SELECT_LSB = 1;
    localparam int CTRL_BUCK_EN_LSB = 3;
    localparam int CTRL_OCMP_EN_LSB = 5;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // boost configuration fields: setpoint [7:0], overvoltage margin [11:8]
    localparam int BCFG_SET_LSB = 0;
    localparam int BCFG_SET_W = 8;
    localparam int BCFG_MARGIN_LSB = 8;
    localparam int BCFG_MARGIN_W = 4;
    localparam logic [BCFG_SET_W-1:0] BCFG_SET_RST = 8'h00;
    localparam logic [BCFG_MARGIN_W-1:0] BCFG_MARGIN_RST = 4'h0;
    localparam int TRIM_W = 4;
    localparam int BSUM_W = 10;
    localparam logic [BSUM_W-1:0] BOOST_MAX_SUM = 10'h0ff;

    // status register fields
    localparam int STAT_BOOST_RUN = 0;
    localparam int STAT_BOOST_OV = 1;
    localparam int STAT_BOOST_BLOCK = 2;
    localparam int STAT_OCFLAG_LSB = 3;
    localparam int STAT_POL_LSB = 5;

    // interrupt status / mask layout
    localparam int IRQ_OV = 0;
    localparam int IRQ_BLOCK = 1;
    localparam int IRQ_SWOC_LSB = 2;
    localparam int IRQ_SNOC_LSB = 4;
    localparam int IRQ_W = 6;
    localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

    // off-time arithmetic
    localparam int VLED_W = 10;
    localparam int TOFF_W = 16;
    localparam logic [11:0] TOFF_SCALE = 12'hfff;
    localparam logic [VLED_W-1:0] VLED_MIN = 10'h001;

    // overcurrent counters
    localparam int SWCNT_W = 4;
    localparam int SNCNT_W = 8;

    // external dimming delay
    localparam int CLK_PERIOD_NS = 8;
    localparam int DIM_DELAY_NS = 4000;
    localparam int DIM_DELAY_CYC = (DIM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_AW = 9;
    localparam int DLY_DEPTH = 512;

    // per-channel buck configuration as held in its register
    typedef struct packed {
        logic [6:0] sense_overcurrent_count_limit;
        logic [2:0] switch_overcurrent_count_limit;
        logic [3:0] buck_offtime_factor;
    } lbb_buck_cfg_s;
    localparam int BUCK_CFG_W = 14;
    localparam lbb_buck_cfg_s BUCK_CFG_RST = 14'h0000;

    // per-channel measurements from the analog front end
    typedef struct packed {
        logic period;
        logic sw_oc;
        logic sense_oc;
        logic [VLED_W-1:0] vled;
    } lbb_meas_s;

    // per-channel commands to the buck power stage
    typedef struct packed {
        logic on;
        logic offset_pol;
        logic [TOFF_W-1:0] toff;
    } lbb_buck_out_s;

endpackage

// ==== core/lbb_delay_mem.sv ====
/*
 * lbb_delay_mem: small dual-port memory used as the dimming delay line.
 * Assumes one clock; read data come out of a register one cycle after raddr.
 */
`timescale 1ns/1ns
module lbb_delay_mem (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_we,
    input wire logic [lbb_pkg::DLY_AW-1:0] i_waddr,
    input wire logic [lbb_pkg::NCH-1:0] i_wdata,
    input wire logic [lbb_pkg::DLY_AW-1:0] i_raddr,
    output logic [lbb_pkg::NCH-1:0] o_rdata
);
    import lbb_pkg::*;

    logic [NCH-1:0] mem [DLY_DEPTH];

    // storage carries no reset so it maps onto a ram
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read port
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// ==== core/lbb_core.sv ====
/*
 * lbb_core: control logic of a dual buck lighting driver with boost supply.
 * Assumes all inputs synchronous to i_ref_clk (125 MHz) and a register
 * master that issues single-cycle read and write strobes.
 */
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module lbb_core (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [lbb_pkg::ADDR_W-1:0] i_addr,
    input wire logic [lbb_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [lbb_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_boost_ov,
    input wire logic i_boost_below_hyst,
    input wire logic [lbb_pkg::TRIM_W-1:0] i_boost_limit_trim,
    input wire lbb_pkg::lbb_meas_s [lbb_pkg::NCH-1:0] i_meas,
    input wire logic [lbb_pkg::NCH-1:0] i_channel_dimming_input,
    input wire logic [lbb_pkg::NCH-1:0] i_int_dim,
    output logic o_boost_run,
    output lbb_pkg::lbb_buck_out_s [lbb_pkg::NCH-1:0] o_buck,
    output logic o_irq
);
    import lbb_pkg::*;

    // register file
    logic [CTRL_W-1:0] ctrl_r;
    logic [BCFG_SET_W-1:0] setpoint_r;
    logic [BCFG_MARGIN_W-1:0] margin_r;
    lbb_buck_cfg_s [NCH-1:0] bcfg_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [DATA_W-1:0] rdata_nxt;

    // address decode
    wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
    wire wr_bcfg = i_wr && (i_addr == REG_BOOST_CFG);
    wire wr_buck1 = i_wr && (i_addr == REG_BUCK1_CFG);
    wire wr_buck2 = i_wr && (i_addr == REG_BUCK2_CFG);
    wire wr_irq_stat = i_wr && (i_addr == REG_IRQ_STAT);
    wire wr_irq_mask = i_wr && (i_addr == REG_IRQ_MASK);
    wire rd_status = i_rd && (i_addr == REG_STATUS);
    wire [NCH-1:0] wr_buck = {wr_buck2, wr_buck1};

    // control fields
    wire boost_en = ctrl_r[CTRL_BOOST_EN_BIT];
    wire [NCH-1:0] dimming_source_select = ctrl_r[CTRL_DIMMING_SOURCE_SELECT_LSB +: NCH];
    wire [NCH-1:0] buck_en = ctrl_r[CTRL_BUCK_EN_LSB +: NCH];
    wire [NCH-1:0] ocmp_en = ctrl_r[CTRL_OCMP_EN_LSB +: NCH];

    // boost state
    logic boost_en_prev_r;
    logic run_req_r;
    logic ov_r;
    logic block_prev_r;
    logic boost_run_r;

    // per-channel state
    logic [NCH-1:0] oc_flag_r;
    logic [NCH-1:0] pol_r;
    logic [NCH-1:0] sw_trip_set;
    logic [NCH-1:0] sn_trip_set;

    // boost limit check, trim takes part in the sum
    wire [BSUM_W-1:0] boost_sum = BSUM_W'(setpoint_r) + BSUM_W'(margin_r) + BSUM_W'(i_boost_limit_trim);
    wire boost_block = boost_sum > BOOST_MAX_SUM;
    wire en_rise = boost_en && !boost_en_prev_r;
    wire en_fall = !boost_en && boost_en_prev_r;
    wire ov_event = i_boost_ov && !ov_r;
    wire block_event = boost_block && !block_prev_r;
    wire boost_run_nxt = run_req_r && !ov_r && !boost_block;

    // register writes
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= CTRL_RST;
            setpoint_r <= BCFG_SET_RST;
            margin_r <= BCFG_MARGIN_RST;
            irq_mask_r <= IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= i_wdata[CTRL_W-1:0];
            end
            if (wr_bcfg) begin
                setpoint_r <= i_wdata[BCFG_SET_LSB +: BCFG_SET_W];
                margin_r <= i_wdata[BCFG_MARGIN_LSB +: BCFG_MARGIN_W];
            end
            if (wr_irq_mask) begin
                irq_mask_r <= i_wdata[IRQ_W-1:0];
            end
        end
    end

    // boost enable edges and overvoltage latch
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boost_en_prev_r <= 1'b0;
            run_req_r <= 1'b0;
            ov_r <= 1'b0;
            block_prev_r <= 1'b0;
            boost_run_r <= 1'b0;
        end else begin
            boost_en_prev_r <= boost_en;
            if (en_rise) begin
                run_req_r <= 1'b1;
            end else if (en_fall) begin
                run_req_r <= 1'b0;
            end
            if (i_boost_ov) begin
                ov_r <= 1'b1;
            end else if (i_boost_below_hyst) begin
                ov_r <= 1'b0;
            end
            block_prev_r <= boost_block;
            boost_run_r <= boost_run_nxt;
        end
    end

    // status flag follows the real run state, not the request
    assign o_boost_run = boost_run_r;

    // external dimming delay line, one bit per channel
    logic [DLY_AW-1:0] wp_r;
    logic [DLY_AW:0] fill_r;
    logic [NCH-1:0] dly_q;
    logic [NCH-1:0] dim_prev_r;
    wire [DLY_AW-1:0] rp = wp_r - DLY_AW'(DIM_DELAY_CYC - 1);
    wire fill_done = fill_r == (DLY_AW + 1)'(DIM_DELAY_CYC);
    // both edges pass the same memory, so the duty cycle is untouched
    wire [NCH-1:0] ext_dly = fill_done ? dly_q : '0;
    wire [NCH-1:0] dim_lvl = (dimming_source_select & ext_dly) | (~dimming_source_select & i_int_dim);
    wire [NCH-1:0] dim_start = dim_lvl & ~dim_prev_r;

    lbb_delay_mem u_dly (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_we(1'b1),
        .i_waddr(wp_r),
        .i_wdata(i_channel_dimming_input),
        .i_raddr(rp),
        .o_rdata(dly_q)
    );

    // write pointer and fill count gate off stale memory after reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wp_r <= '0;
            fill_r <= '0;
            dim_prev_r <= '0;
        end else begin
            wp_r <= wp_r + 1'b1;
            if (!fill_done) begin
                fill_r <= fill_r + 1'b1;
            end
            dim_prev_r <= dim_lvl;
        end
    end

    // per-channel buck logic
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic [SWCNT_W-1:0] sw_cnt_r;
            logic [SNCNT_W-1:0] sn_cnt_r;
            logic sw_trip_r;
            logic sn_trip_r;
            logic [TOFF_W-1:0] toff_r;
            wire cnt_clr = !buck_en[c] || dim_start[c];
            wire flag_read = rd_status && oc_flag_r[c];
            wire sw_step = i_meas[c].period && i_meas[c].sw_oc && !sw_trip_r;
            wire sn_step = i_meas[c].period && i_meas[c].sense_oc && !sn_trip_r;
            wire [SWCNT_W-1:0] sw_lim = SWCNT_W'(bcfg_r[c].switch_overcurrent_count_limit) + 1'b1;
            wire [SNCNT_W-1:0] sn_lim = SNCNT_W'(bcfg_r[c].sense_overcurrent_count_limit) + 1'b1;
            wire [SWCNT_W-1:0] sw_inc = sw_cnt_r + 1'b1;
            wire [SNCNT_W-1:0] sn_inc = sn_cnt_r + 1'b1;
            wire [VLED_W-1:0] vled_safe = (i_meas[c].vled < VLED_MIN) ? VLED_MIN : i_meas[c].vled;
            wire [TOFF_W-1:0] toff_num = TOFF_W'(bcfg_r[c].buck_offtime_factor) * TOFF_W'(TOFF_SCALE);
            assign sw_trip_set[c] = sw_step && !cnt_clr && (sw_inc == sw_lim);
            assign sn_trip_set[c] = sn_step && !cnt_clr && (sn_inc == sn_lim);

            // counters restart after a trip so a released channel counts afresh
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sw_cnt_r <= '0;
                    sn_cnt_r <= '0;
                end else begin
                    if (cnt_clr || sw_trip_set[c]) begin
                        sw_cnt_r <= '0;
                    end else if (sw_step) begin
                        sw_cnt_r <= sw_inc;
                    end
                    if (cnt_clr || sn_trip_set[c]) begin
                        sn_cnt_r <= '0;
                    end else if (sn_step) begin
                        sn_cnt_r <= sn_inc;
                    end
                end
            end

            // trips hold the channel off until the flag is read; new trip wins
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sw_trip_r <= 1'b0;
                    sn_trip_r <= 1'b0;
                    oc_flag_r[c] <= 1'b0;
                end else begin
                    sw_trip_r <= sw_trip_set[c] || (sw_trip_r && !flag_read);
                    sn_trip_r <= sn_trip_set[c] || (sn_trip_r && !flag_read);
                    oc_flag_r[c] <= sw_trip_set[c] || sn_trip_set[c] || (oc_flag_r[c] && !flag_read);
                end
            end

            // offset polarity and off-time
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    pol_r[c] <= 1'b0;
                    toff_r <= '0;
                end else begin
                    if (!ocmp_en[c]) begin
                        pol_r[c] <= 1'b0;
                    end else if (i_meas[c].period) begin
                        pol_r[c] <= !pol_r[c];
                    end
                    toff_r <= toff_num / TOFF_W'(vled_safe);
                end
            end

            assign o_buck[c].on = buck_en[c] && dim_lvl[c] && !sw_trip_r && !sn_trip_r;
            assign o_buck[c].offset_pol = pol_r[c];
            assign o_buck[c].toff = toff_r;
        end
    endgenerate

    // buck configuration registers
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bcfg_r <= {NCH{BUCK_CFG_RST}};
        end else begin
            for (int k = 0; k < NCH; k++) begin
                if (wr_buck[k]) begin
                    bcfg_r[k] <= lbb_buck_cfg_s'(i_wdata[BUCK_CFG_W-1:0]);
                end
            end
        end
    end

    // interrupt status: events set, write one clears, set wins
    wire [IRQ_W-1:0] irq_ev = {sn_trip_set, sw_trip_set, block_event, ov_event};
    wire [IRQ_W-1:0] irq_clr = wr_irq_stat ? i_wdata[IRQ_W-1:0] : '0;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_r <= IRQ_RST;
        end else begin
            irq_stat_r <= irq_ev | (irq_stat_r & ~irq_clr);
        end
    end
    assign o_irq = |(irq_stat_r & irq_mask_r);

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = '0;
        case (i_addr)
            REG_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
            REG_BOOST_CFG: begin
                rdata_nxt[BCFG_SET_LSB +: BCFG_SET_W] = setpoint_r;
                rdata_nxt[BCFG_MARGIN_LSB +: BCFG_MARGIN_W] = margin_r;
            end
            REG_BUCK1_CFG: rdata_nxt[BUCK_CFG_W-1:0] = bcfg_r[0];
            REG_BUCK2_CFG: rdata_nxt[BUCK_CFG_W-1:0] = bcfg_r[1];
            REG_STATUS: begin
                rdata_nxt[STAT_BOOST_RUN] = boost_run_r;
                rdata_nxt[STAT_BOOST_OV] = ov_r;
                rdata_nxt[STAT_BOOST_BLOCK] = boost_block;
                rdata_nxt[STAT_OCFLAG_LSB +: NCH] = oc_flag_r;
                rdata_nxt[STAT_POL_LSB +: NCH] = pol_r;
            end
            REG_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
            REG_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = irq_mask_r;
            default: rdata_nxt = '0;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rdata_nxt : '0;
        end
    end
endmodule

// ==== sim/lbb_core_properties.sv ====
/* lbb_core_properties: port-level checker for lbb_core, with shadows of the
   control and boost config words and the channel one off-time factor. Assumes a bind onto lbb_core. */
`timescale 1ns/1ns
module lbb_core_properties (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [lbb_pkg::ADDR_W-1:0] i_addr,
    input wire logic [lbb_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [lbb_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_boost_ov,
    input wire logic i_boost_below_hyst,
    input wire logic [lbb_pkg::TRIM_W-1:0] i_boost_limit_trim,
    input wire lbb_pkg::lbb_meas_s [lbb_pkg::NCH-1:0] i_meas,
    input wire logic [lbb_pkg::NCH-1:0] i_channel_dimming_input,
    input wire logic [lbb_pkg::NCH-1:0] i_int_dim,
    input wire logic o_boost_run,
    input wire lbb_pkg::lbb_buck_out_s [lbb_pkg::NCH-1:0] o_buck,
    input wire logic o_irq
);
    import lbb_pkg::*;
    logic [CTRL_W-1:0] ctrl_r;
    logic [11:0] bcfg_r;
    logic [3:0] fac_r;
    logic over_limit;
    logic [15:0] vdiv;
    logic [15:0] toff_exp;

    // shadows follow the same write strobes the block decodes
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= '0;
            bcfg_r <= '0;
            fac_r <= '0;
        end else if (i_wr) begin
            if (i_addr == REG_CTRL) ctrl_r <= i_wdata[CTRL_W-1:0];
            if (i_addr == REG_BOOST_CFG) bcfg_r <= i_wdata[11:0];
            if (i_addr == REG_BUCK1_CFG) fac_r <= i_wdata[3:0];
        end
    end

    // ten-bit sum so a full setpoint plus margin cannot wrap
    assign over_limit = (10'(bcfg_r[7:0]) + 10'(bcfg_r[11:8]) + 10'(i_boost_limit_trim)) > BOOST_MAX_SUM;
    assign vdiv = (i_meas[0].vled == '0) ? 16'(VLED_MIN) : 16'(i_meas[0].vled);
    assign toff_exp = (16'(fac_r) * 16'(TOFF_SCALE)) / vdiv;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    chk_boost_start: assert property ($rose(o_boost_run) |-> $past(ctrl_r[CTRL_BOOST_EN_BIT], 2))
        else $error("boost started without enable");
    chk_boost_stop: assert property ($fell(ctrl_r[CTRL_BOOST_EN_BIT]) |-> ##2 !o_boost_run)
        else $error("boost kept running after disable");
    chk_ov_halt: assert property (i_boost_ov |-> ##2 !o_boost_run)
        else $error("boost running through overvoltage");
    chk_limit_block: assert property (over_limit [*3] |-> !o_boost_run)
        else $error("boost running above the limit");
    chk_offtime_calc: assert property (o_buck[0].toff == $past(toff_exp))
        else $error("off-time value wrong");
    chk_pol_toggle: assert property (i_meas[0].period && ctrl_r[CTRL_OCMP_EN_LSB]
        |=> o_buck[0].offset_pol != $past(o_buck[0].offset_pol))
        else $error("offset polarity did not flip");
    chk_int_dim: assert property (!ctrl_r[CTRL_DIMMING_SOURCE_SELECT_LSB] && o_buck[0].on |-> i_int_dim[0])
        else $error("channel one on without internal dim");
    chk_ext_dim: assert property (ctrl_r[CTRL_DIMMING_SOURCE_SELECT_LSB+1] && o_buck[1].on
        |-> $past(i_channel_dimming_input[1], 500))
        else $error("channel two not following delayed pin");

    cover property ($rose(o_boost_run));
    cover property ($fell(o_buck[0].on) && ctrl_r[CTRL_BUCK_EN_LSB]);
    cover property ($rose(o_irq));
endmodule

// ==== sim/lbb_mcu_model.sv ====
/* lbb_mcu_model: microcontroller side, register strobes and dimming pins.
   Assumes one clock shared with the core and a zero-wait slave. */
`timescale 1ns/1ns
module lbb_mcu_model (
    input wire logic i_ref_clk,
    input wire logic [lbb_pkg::DATA_W-1:0] i_rdata,
    output logic [lbb_pkg::ADDR_W-1:0] o_addr,
    output logic [lbb_pkg::DATA_W-1:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic [lbb_pkg::NCH-1:0] o_dim
);
    import lbb_pkg::*;
    // idle bus at time zero
    initial begin
        o_addr = '0;
        o_wdata = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_dim = '0;
    end
    // one strobe cycle; released lines turn over so stale values never match
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // data stand only in the cycle after the strobe, taken mid-cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(negedge i_ref_clk);
        d = i_rdata;
    endtask
    // pin levels; callers keep dim periods far shorter than 3.3 ms
    task automatic dim(input int ch, input logic v);
        @(posedge i_ref_clk);
        o_dim[ch] <= v;
    endtask
endmodule

// ==== sim/tb_lbb_core.sv ====
/* tb_lbb_core: self-checking bench for lbb_core with the controller model.
   Assumes a 125 MHz clock and the checker bound below. */
`timescale 1ns/1ns
module tb_lbb_core;
    import lbb_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [DATA_W-1:0] o_rdata;
    logic i_boost_ov = 1'b0;
    logic i_boost_below_hyst = 1'b0;
    logic [TRIM_W-1:0] i_boost_limit_trim = 4'h2;
    lbb_meas_s [NCH-1:0] i_meas = '0;
    logic [NCH-1:0] i_channel_dimming_input;
    logic [NCH-1:0] i_int_dim = 2'h1;
    logic o_boost_run;
    lbb_buck_out_s [NCH-1:0] o_buck;
    logic o_irq;
    int err_total = 0;
    int checks_done = 0;
    logic [DATA_W-1:0] rv;
    int n1;
    int n2;

    // 8 ns clock
    always #4 i_ref_clk = ~i_ref_clk;

    lbb_core DUT (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_boost_ov,
        .i_boost_below_hyst, .i_boost_limit_trim, .i_meas, .i_channel_dimming_input, .i_int_dim,
        .o_boost_run, .o_buck, .o_irq);
    lbb_mcu_model mcu (.i_ref_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd), .o_dim(i_channel_dimming_input));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp(16'(got), 16'(exp), what);
    endtask
    // settle past the edge before looking
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
    task automatic pulse(input int ch, input logic sw, input logic sn, input int n);
        repeat (n) begin
            @(posedge i_ref_clk);
            i_meas[ch].period <= 1'b1;
            i_meas[ch].sw_oc <= sw;
            i_meas[ch].sense_oc <= sn;
            @(posedge i_ref_clk);
            i_meas[ch].period <= 1'b0;
            tick(1);
        end
    endtask
    // bounded count of cycles until channel two reaches a level, looked at mid-cycle
    task automatic lag(input logic lv, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (o_buck[1].on !== lv && n < 600);
    endtask

    task automatic t_boost();
        mcu.wr(REG_CTRL, 16'h0001);
        tick(1);
        cmp_bit(o_boost_run, 1'b0, "run early");
        tick(0);
        tick(0);
        cmp_bit(o_boost_run, 1'b1, "run on");
        @(posedge i_ref_clk);
        i_boost_ov <= 1'b1;
        @(posedge i_ref_clk);
        i_boost_ov <= 1'b0;
        mcu.rd(REG_STATUS, rv);
        cmp(rv[2:0], 3'h2, "status ov");
        @(posedge i_ref_clk);
        i_boost_below_hyst <= 1'b1;
        @(posedge i_ref_clk);
        i_boost_below_hyst <= 1'b0;
        tick(3);
        cmp_bit(o_boost_run, 1'b1, "run resumed");
        mcu.wr(REG_BOOST_CFG, 16'h00fe);
        tick(3);
        cmp_bit(o_boost_run, 1'b0, "run over limit");
        mcu.wr(REG_BOOST_CFG, 16'h00fd);
        tick(3);
        cmp_bit(o_boost_run, 1'b1, "run at limit");
        mcu.wr(REG_CTRL, 16'h0000);
        tick(3);
        cmp_bit(o_boost_run, 1'b0, "run off");
        mcu.wr(8'h1c, 16'hffff);
        mcu.rd(8'h1c, rv);
        cmp(rv, 16'h0000, "unmapped");
        $display("t_boost done");
    endtask

    task automatic t_toff();
        @(posedge i_ref_clk);
        i_meas[0].vled <= 10'h00c;
        mcu.wr(REG_BUCK1_CFG, 16'h0003);
        tick(2);
        cmp(o_buck[0].toff, (16'h3 * 16'(TOFF_SCALE)) / 16'hc, "toff");
        @(posedge i_ref_clk);
        i_meas[0].vled <= 10'h000;
        tick(2);
        cmp(o_buck[0].toff, 16'h3 * 16'(TOFF_SCALE), "toff zero");
        $display("t_toff done");
    endtask

    task automatic t_oc();
        mcu.wr(REG_IRQ_STAT, 16'h003f);
        mcu.wr(REG_IRQ_MASK, 16'h003f);
        mcu.wr(REG_BUCK1_CFG, 16'h02a0);
        mcu.wr(REG_CTRL, 16'h0008);
        pulse(0, 1'b1, 1'b0, 2);
        @(posedge i_ref_clk);
        i_int_dim[0] <= 1'b0;
        tick(1);
        cmp_bit(o_buck[0].on, 1'b0, "dim low");
        @(posedge i_ref_clk);
        i_int_dim[0] <= 1'b1;
        pulse(0, 1'b1, 1'b0, 2);
        cmp_bit(o_buck[0].on, 1'b1, "dim clears");
        mcu.wr(REG_CTRL, 16'h0000);
        mcu.wr(REG_CTRL, 16'h0008);
        pulse(0, 1'b1, 1'b0, 2);
        cmp_bit(o_buck[0].on, 1'b1, "disable clears");
        pulse(0, 1'b1, 1'b0, 1);
        tick(20);
        cmp_bit(o_buck[0].on, 1'b0, "switch trip");
        mcu.rd(REG_STATUS, rv);
        cmp_bit(rv[STAT_OCFLAG_LSB], 1'b1, "flag");
        tick(2);
        cmp_bit(o_buck[0].on, 1'b1, "released");
        pulse(0, 1'b0, 1'b1, 5);
        cmp_bit(o_buck[0].on, 1'b1, "sense below");
        pulse(0, 1'b0, 1'b1, 1);
        tick(2);
        cmp_bit(o_buck[0].on, 1'b0, "sense trip");
        cmp_bit(o_irq, 1'b1, "irq");
        mcu.rd(REG_STATUS, rv);
        tick(2);
        cmp_bit(o_buck[0].on, 1'b1, "sense release");
        mcu.rd(REG_IRQ_STAT, rv);
        cmp(rv, 16'h0014, "irq stat");
        mcu.wr(REG_IRQ_MASK, 16'h0000);
        tick(1);
        cmp_bit(o_irq, 1'b0, "irq masked");
        mcu.wr(REG_IRQ_STAT, 16'h0014);
        mcu.wr(REG_IRQ_MASK, 16'h003f);
        tick(1);
        cmp_bit(o_irq, 1'b0, "irq cleared");
        $display("t_oc done");
    endtask

    task automatic t_pol();
        mcu.wr(REG_CTRL, 16'h0028);
        pulse(0, 1'b0, 1'b0, 1);
        cmp_bit(o_buck[0].offset_pol, 1'b1, "pol 1");
        pulse(0, 1'b0, 1'b0, 1);
        cmp_bit(o_buck[0].offset_pol, 1'b0, "pol 2");
        pulse(0, 1'b0, 1'b0, 1);
        mcu.wr(REG_CTRL, 16'h0008);
        tick(1);
        cmp_bit(o_buck[0].offset_pol, 1'b0, "pol off");
        $display("t_pol done");
    endtask

    task automatic t_ext();
        @(posedge i_ref_clk);
        i_int_dim[0] <= 1'b0;
        mcu.wr(REG_CTRL, 16'h001c);
        mcu.dim(0, 1'b1);
        mcu.dim(1, 1'b1);
        lag(1'b1, n1);
        cmp(16'(n1), 16'(DIM_DELAY_CYC), "rise lag");
        cmp_bit(o_buck[0].on, 1'b0, "ch1 internal");
        mcu.dim(1, 1'b0);
        lag(1'b0, n2);
        cmp(16'(n2), 16'(n1), "fall lag");
        mcu.dim(0, 1'b0);
        $display("t_ext done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reset then the scenarios in turn
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        t_boost();
        t_toff();
        t_oc();
        t_pol();
        t_ext();
        test_done();
    end
    // watchdog: the scenarios need under 2000 cycles
    initial begin
        #80000;
        err_total++;
        test_done();
    end
endmodule

bind lbb_core lbb_core_properties chk (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_boost_ov, .i_boost_below_hyst, .i_boost_limit_trim, .i_meas, .i_channel_dimming_input, .i_int_dim,
    .o_boost_run, .o_buck, .o_irq);
